// *** rtl/alarm_qualify_escalate.sv ***
/*
  Alarm qualification, escalation and event reporting for a timing
  reference controller, with a classic Wishbone register slave.
  Assumes one clock, a synchronous reset and a one-cycle tick_i per second;
  condition inputs are synchronous levels; the event sink handshakes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aqe_regs.svh"

module alarm_qualify_escalate #(
  parameter int N_ALARM = `AQE_NALM,
  parameter int DLY_W = 16
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // alarm sources
  input wire logic [N_ALARM-1:0] cond_i,
  input wire logic [N_ALARM-1:0] present_i,
  output logic [2*N_ALARM-1:0] level_o,
  output logic minor_o,
  output logic major_o,
  output logic critical_o,
  // event reports
  input wire aqe_pkg::op_in_t op_i,
  input wire logic evt_ready_i,
  output logic evt_valid_o,
  output aqe_pkg::evt_t evt_o
);

  localparam int TW = `AQE_TMR_W;
  localparam int NOP = `AQE_NOP;

  if (N_ALARM < 1 || N_ALARM > `AQE_NALM || DLY_W < 1 || DLY_W > 16) begin : g_bad
    $error("alarm count or delay width out of range");
  end

  typedef struct packed {
    logic [`AQE_ELEV_W-1:0] elev;
    logic [N_ALARM-1:0] pres_en;
    logic [N_ALARM-1:0] prev;
    logic [N_ALARM-1:0] apend;
    logic [N_ALARM-1:0][1:0] cfg;
    logic [N_ALARM-1:0][1:0] cur;
    logic [N_ALARM-1:0][DLY_W-1:0] dly;
    logic [N_ALARM-1:0][TW-1:0] tmr;
    logic [NOP-1:0] opend;
    logic [NOP-1:0][31:0] oparg;
    logic [31:0] stamp;
    logic evt_v;
    aqe_pkg::evt_t evt;
    logic ack;
    logic [31:0] dat;
    logic mn;
    logic mj;
    logic cr;
  } st_t;

  st_t s_r, s_nxt;

  logic [N_ALARM-1:0] eff_w, qual_w, elv_w;
  logic [N_ALARM-1:0][1:0] lvl_w;

  function automatic logic [DLY_W-1:0] def_dly(input int i);
    logic [15:0] d;
    d = 16'h0000;
    if (i == 0 || i == 8 || i == 16) d = `AQE_DLY_300;
    if (i == 9) d = `AQE_DLY_600;
    return d[DLY_W-1:0];
  endfunction

  localparam logic [2*`AQE_NALM-1:0] LVL_DEF = `AQE_LVL_DEF;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  genvar g;
  for (g = 0; g < N_ALARM; g++) begin : g_alm
    logic [TW-1:0] dl;
    logic [TW-1:0] esc;
    assign dl = TW'(s_r.dly[g]);
    assign esc = dl + TW'(s_r.elev);
    assign eff_w[g] = cond_i[g] & present_i[g] & s_r.pres_en[g];
    assign qual_w[g] = eff_w[g] && s_r.tmr[g] >= dl;
    assign elv_w[g] = qual_w[g] && s_r.tmr[g] >= esc;
    // ignored alarms never escalate, critical is the ceiling
    always_comb begin
      lvl_w[g] = 2'h0;
      if (qual_w[g]) begin
        lvl_w[g] = s_r.cfg[g];
        if (elv_w[g] && s_r.cfg[g] != 2'h0 && s_r.cfg[g] != 2'h3) lvl_w[g] = s_r.cfg[g] + 2'h1;
      end
    end

    delay_hold_a: assert property (s_r.tmr[g] < dl |-> lvl_w[g] == 2'h0)
      else $error("alarm level raised before its delay");
    timer_restart_a: assert property (!eff_w[g] |=> s_r.tmr[g] == '0)
      else $error("alarm timer not restarted after clear");
    escalate_minor_a: assert property (elv_w[g] && s_r.cfg[g] == 2'h1 |-> lvl_w[g] == 2'h2)
      else $error("minor alarm did not step up to major");
    ignored_quiet_a: assert property (s_r.cfg[g] == 2'h0 |-> lvl_w[g] == 2'h0)
      else $error("ignored alarm raised a level");
    critical_ceiling_a: assert property (qual_w[g] && s_r.cfg[g] == 2'h3 |-> lvl_w[g] == 2'h3)
      else $error("critical alarm left its level");
    absent_quiet_a: assert property (!present_i[g] |=> level_o[2*g +: 2] == 2'h0)
      else $error("absent source shows a level");
  end

  logic [11:0] a_w;
  assign a_w = {adr_i, 2'b00};

  always_comb begin
    logic [31:0] rv;
    logic [31:0] m;
    logic [31:0] wm;
    logic [11:0] off;
    logic [N_ALARM-1:0] aset;
    logic [N_ALARM-1:0] aclr;
    logic [NOP-1:0] oset;
    logic [NOP-1:0] oclr;
    logic [NOP-1:0] opulse;
    logic [NOP-1:0][31:0] oarg;
    logic hit;
    logic cfg_hit;
    int ci;
    rv = 32'h0000_0000;
    m = 32'h0000_0000;
    wm = 32'h0000_0000;
    off = a_w - `AQE_CFG_BASE;
    aset = '0;
    aclr = '0;
    oset = '0;
    oclr = '0;
    opulse = '0;
    oarg = '0;
    hit = 1'b0;
    ci = int'(off[11:2]);
    cfg_hit = a_w >= `AQE_CFG_BASE && ci < N_ALARM;
    s_nxt = s_r;

    case (a_w)
      `AQE_ELEV_OFS: rv = 32'(s_r.elev);
      `AQE_PRES_OFS: rv = 32'(s_r.pres_en);
      `AQE_COND_OFS: rv = 32'(eff_w);
      `AQE_QUAL_OFS: rv = 32'(qual_w);
      `AQE_STAMP_OFS: rv = s_r.stamp;
      default: begin
        if (cfg_hit) begin
          rv[`AQE_CFG_LVL +: 2] = s_r.cfg[ci];
          rv[`AQE_CFG_CUR +: 2] = s_r.cur[ci];
          rv[`AQE_CFG_QUAL] = qual_w[ci];
          rv[`AQE_CFG_DLY +: DLY_W] = s_r.dly[ci];
        end
      end
    endcase
    for (int b = 0; b < 4; b++) m[8*b +: 8] = {8{sel_i[b]}};
    wm = (rv & ~m) | (dat_i & m);

    // single-cycle wait state keeps the read mux off the output path
    s_nxt.ack = cyc_i && stb_i && !s_r.ack;
    s_nxt.dat = rv;
    // writes land at the edge at which the master sees ack, never earlier
    if (cyc_i && stb_i && we_i && s_r.ack) begin
      case (a_w)
        `AQE_ELEV_OFS: s_nxt.elev = wm[`AQE_ELEV_W-1:0] > `AQE_ELEV_MAX ? `AQE_ELEV_MAX : wm[`AQE_ELEV_W-1:0];
        `AQE_PRES_OFS: s_nxt.pres_en = wm[N_ALARM-1:0];
        default: begin
          // level and delay by alarm number
          if (cfg_hit) begin
            s_nxt.cfg[ci] = wm[`AQE_CFG_LVL +: 2];
            s_nxt.dly[ci] = wm[`AQE_CFG_DLY +: DLY_W];
          end
        end
      endcase
    end

    // timers count seconds only while the condition stands
    for (int i = 0; i < N_ALARM; i++) begin
      if (!eff_w[i]) s_nxt.tmr[i] = '0;
      else if (tick_i && s_r.tmr[i] != '1) s_nxt.tmr[i] = s_r.tmr[i] + TW'(1);
    end
    s_nxt.cur = lvl_w;
    s_nxt.mn = 1'b0;
    s_nxt.mj = 1'b0;
    s_nxt.cr = 1'b0;
    for (int i = 0; i < N_ALARM; i++) begin
      s_nxt.mn = s_nxt.mn | (lvl_w[i] == 2'h1);
      s_nxt.mj = s_nxt.mj | (lvl_w[i] == 2'h2);
      s_nxt.cr = s_nxt.cr | (lvl_w[i] == 2'h3);
    end
    if (tick_i) s_nxt.stamp = s_r.stamp + 32'h1;

    s_nxt.prev = qual_w;
    aset = qual_w ^ s_r.prev;
    opulse = {op_i.receiver_found_event, op_i.sync_change, op_i.position_override,
      op_i.user_set_saved_event, op_i.defaults_restored_event, op_i.loop_mode_event, op_i.log_cleared_event};
    oarg[0] = {20'h00000, op_i.log_port, op_i.log_user};
    oarg[1] = {29'h00000000, op_i.holdover_state, op_i.loop_state};
    oarg[2] = {22'h000000, op_i.def_set, op_i.def_user};
    oarg[3] = {24'h000000, op_i.save_user};
    oarg[4] = {16'h0000, op_i.avg_count};
    oarg[5] = {31'h00000000, op_i.sync_master};
    oarg[6] = op_i.receiver_rev;
    for (int k = 0; k < NOP; k++) begin
      if (opulse[k]) begin
        oset[k] = 1'b1;
        s_nxt.oparg[k] = oarg[k];
      end
    end

    // unprompted report, alarms before operating events
    if (!s_r.evt_v || evt_ready_i) begin
      s_nxt.evt_v = 1'b0;
      for (int i = N_ALARM - 1; i >= 0; i--) begin
        if (s_r.apend[i]) begin
          hit = 1'b1;
          aclr = '0;
          aclr[i] = 1'b1;
          s_nxt.evt.num = 6'(i);
          s_nxt.evt.p1 = 32'(s_r.dly[i]);
          s_nxt.evt.p2 = {29'h00000000, qual_w[i], lvl_w[i]};
        end
      end
      for (int k = NOP - 1; k >= 0; k--) begin
        if (!hit && s_r.opend[k]) begin
          oclr = '0;
          oclr[k] = 1'b1;
          s_nxt.evt.num = `AQE_EVT_OP_BASE + 6'(k);
          s_nxt.evt.p1 = s_r.oparg[k];
          s_nxt.evt.p2 = 32'h0000_0000;
        end
      end
      if (hit || oclr != '0) begin
        s_nxt.evt_v = 1'b1;
        s_nxt.evt.stamp = s_r.stamp;
      end
    end
    // a new request in the clearing cycle survives
    s_nxt.apend = (s_r.apend & ~aclr) | aset;
    s_nxt.opend = (s_r.opend & ~oclr) | oset;

    if (rst_i) begin
      s_nxt = '0;
      s_nxt.elev = `AQE_ELEV_DEF;
      s_nxt.pres_en = '1;
      for (int i = 0; i < N_ALARM; i++) begin
        s_nxt.cfg[i] = LVL_DEF[2*i +: 2];
        s_nxt.dly[i] = def_dly(i);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign dat_o = s_r.dat;
  assign ack_o = s_r.ack;
  assign level_o = s_r.cur;
  assign minor_o = s_r.mn;
  assign major_o = s_r.mj;
  assign critical_o = s_r.cr;
  assign evt_valid_o = s_r.evt_v;
  assign evt_o = s_r.evt;

  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  elev_range_a: assert property (s_r.elev <= `AQE_ELEV_MAX)
    else $error("elevation time out of range");
  elev_default_a: assert property (@(posedge clk_i) $past(rst_i) |-> s_r.elev == `AQE_ELEV_DEF)
    else $error("elevation time not reset to default");
  evt_hold_a: assert property (evt_valid_o && !evt_ready_i |=> evt_valid_o && $stable(evt_o))
    else $error("event report dropped before taken");
  alarm_evt_delay_a: assert property (evt_valid_o && evt_o.num < 6'(N_ALARM)
    && $stable(s_r.dly) |-> evt_o.p1 == 32'(s_r.dly[evt_o.num]))
    else $error("alarm event lacks its delay");
  alarm_evt_num_a: assert property (evt_valid_o && evt_o.num < `AQE_EVT_OP_BASE |-> evt_o.num < `AQE_EVT_ALARM_LIM)
    else $error("alarm event number out of range");
  log_evt_a: assert property (op_i.log_cleared_event && !s_r.opend[0] |=> s_r.opend[0])
    else $error("log clear event not recorded");
  sync_evt_a: assert property (op_i.sync_change |=> s_r.opend[5] && s_r.oparg[5][0] == $past(op_i.sync_master))
    else $error("sync change event not recorded");

endmodule
`default_nettype wire

// *** shared/aqe_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  alarm qualify/escalate block. Assumes byte addresses on a 32-bit bus.
*/
`ifndef AQE_REGS_SVH
`define AQE_REGS_SVH

`define AQE_NALM 24
// register byte offsets
`define AQE_ELEV_OFS 12'h000
`define AQE_PRES_OFS 12'h004
`define AQE_COND_OFS 12'h008
`define AQE_QUAL_OFS 12'h00c
`define AQE_STAMP_OFS 12'h010
`define AQE_CFG_BASE 12'h100
// per-alarm config word fields
`define AQE_CFG_LVL 0
`define AQE_CFG_CUR 4
`define AQE_CFG_QUAL 8
`define AQE_CFG_DLY 16
// elevation time in seconds
`define AQE_ELEV_W 18
`define AQE_ELEV_MAX 18'h294f0
`define AQE_ELEV_DEF 18'h14a78
// alarm timer width, seconds
`define AQE_TMR_W 19
// default delays in seconds
`define AQE_DLY_300 16'h012c
`define AQE_DLY_600 16'h0258
// default levels, two bits per alarm, alarm 23 leftmost
`define AQE_LVL_DEF {2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2, \
  2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h1}
// event numbering
`define AQE_EVT_ALARM_LIM 6'h1f
`define AQE_EVT_OP_BASE 6'h29
`define AQE_NOP 7

`endif

// *** shared/aqe_pkg.sv ***
/*
  Types of the alarm qualify/escalate block: severity levels, the operating
  event request bundle and the event report carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aqe_pkg;

  typedef enum logic [1:0] {LVL_IGNORED, LVL_MINOR, LVL_MAJOR, LVL_CRITICAL} level_t;

  // operating change requests, each strobe a one-cycle pulse
  typedef struct packed {
    logic log_cleared_event;
    logic [7:0] log_user;
    logic [3:0] log_port;
    logic loop_mode_event;
    logic holdover_state;
    logic [1:0] loop_state;
    logic defaults_restored_event;
    logic [7:0] def_user;
    logic [1:0] def_set;
    logic user_set_saved_event;
    logic [7:0] save_user;
    logic position_override;
    logic [15:0] avg_count;
    logic sync_change;
    logic sync_master;
    logic receiver_found_event;
    logic [31:0] receiver_rev;
  } op_in_t;

  typedef struct packed {
    logic [5:0] num;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] stamp;
  } evt_t;

endpackage

// *** verif/term_sink.sv ***
/*
  Operator terminal model: takes event reports, either at once or one
  cycle in four. Assumes the block's clock and synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module term_sink (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // report handshake
  input wire logic slow_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic got_o
);
  logic [1:0] cnt_r;
  // a slow terminal stalls three cycles in four to exercise the hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign ready_o = slow_i ? (cnt_r == 2'h3) : 1'b1;
  assign got_o = valid_i & ready_o;
endmodule
`default_nettype wire

// *** verif/alarm_qualify_escalate_bench.sv ***
/*
  Self-checking bench of the alarm block: defaults, delay, escalation,
  masking, register access and event reports.
  Assumes the terminal model term_sink and the offsets of aqe_regs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aqe_regs.svh"
module alarm_qualify_escalate_bench;
  logic clk_i, rst_i, tick_i, tick_en, cyc_i, stb_i, we_i, ack_o, evt_valid_o, evt_ready_i, slow, got;
  logic minor_o, major_o, critical_o;
  logic [11:2] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [23:0] cond_i, present_i;
  logic [47:0] level_o;
  aqe_pkg::op_in_t op_i, o;
  aqe_pkg::evt_t evt_o;
  aqe_pkg::evt_t evq[$];
  int num_errors = 0;
  int checks_done = 0;
  typedef struct {int idx; logic [1:0] lvl; logic [15:0] dly;} row_t;
  row_t rows[5] = '{'{0, 2'h1, 16'h012c}, '{1, 2'h2, 16'h0000}, '{2, 2'h2, 16'h0000},
    '{9, 2'h1, 16'h0258}, '{21, 2'h0, 16'h0000}};
  logic [31:0] ep[7] = '{32'h35a, 32'h6, 32'h321, 32'h44, 32'h1234, 32'h1, 32'hc0de0102};

  alarm_qualify_escalate i_dut (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .cond_i(cond_i), .present_i(present_i), .level_o(level_o), .minor_o(minor_o),
    .major_o(major_o), .critical_o(critical_o), .op_i(op_i), .evt_ready_i(evt_ready_i),
    .evt_valid_o(evt_valid_o), .evt_o(evt_o));
  term_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(evt_valid_o),
    .ready_o(evt_ready_i), .got_o(got));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tick_i <= tick_en;
    if (got === 1'b1) evq.push_back(evt_o);
  end

  task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a[11:2]; dat_i <= d; sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
  endtask
  function automatic logic [31:0] lv(int i);
    return 32'(level_o[2*i+:2]);
  endfunction
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    print_verdict;
  end

  initial begin
    rst_i = 1'b1; tick_en = 1'b0; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; slow = 1'b0;
    adr_i = '0; sel_i = '0; dat_i = '0; cond_i = '0; present_i = '1; op_i = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[k]) begin
      wb(1'b0, `AQE_CFG_BASE + 12'(4 * rows[k].idx), 32'h0);
      cmp(32'(q[1:0]), 32'(rows[k].lvl), "default level");
      cmp(32'(q[31:16]), 32'(rows[k].dly), "default delay");
    end
    wb(1'b0, `AQE_ELEV_OFS, 32'h0); cmp(q, 32'h14a78, "elevation default");
    wb(1'b1, `AQE_ELEV_OFS, 32'h30d40); wb(1'b0, `AQE_ELEV_OFS, 32'h0);
    cmp(q, 32'h294f0, "elevation clamp");
    wb(1'b0, 12'h0f0, 32'h0); cmp(q, 32'h0, "unmapped read");
    wb(1'b1, `AQE_ELEV_OFS, 32'h64);
    evq.delete(); cond_i[1] <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmp(lv(1), 32'h2, "immediate major");
    cmp(32'(major_o), 32'h1, "major summary");
    cmp(32'(evq[0].num), 32'h1, "alarm event number");
    cmp(evq[0].p1, 32'h0, "alarm event delay");
    cmp(evq[0].p2, 32'h6, "alarm event state");
    wb(1'b0, `AQE_COND_OFS, 32'h0); cmp(q, 32'h2, "condition query");
    present_i[1] <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp(lv(1), 32'h0, "absent suppressed");
    wb(1'b0, `AQE_COND_OFS, 32'h0); cmp(q, 32'h0, "absent query");
    cond_i[1] <= 1'b0; present_i[1] <= 1'b1;
    wb(1'b1, `AQE_CFG_BASE + 12'h024, 32'h00050001);
    cond_i[9] <= 1'b1; cond_i[21] <= 1'b1; tick_en <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp(lv(9), 32'h0, "held in delay");
    repeat (20) @(posedge clk_i);
    cmp(lv(9), 32'h1, "minor after delay");
    cmp(32'(minor_o), 32'h1, "minor summary");
    wb(1'b1, `AQE_ELEV_OFS, 32'h3);
    repeat (6) @(posedge clk_i);
    cmp(lv(9), 32'h2, "escalated to major");
    cmp(lv(21), 32'h0, "ignored stays");
    tick_en <= 1'b0; cond_i[9] <= 1'b0;
    repeat (4) @(posedge clk_i);
    cond_i[9] <= 1'b1;
    repeat (6) @(posedge clk_i);
    cmp(lv(9), 32'h0, "timer restarted");
    cond_i <= '0;
    repeat (30) @(posedge clk_i);
    evq.delete(); slow <= 1'b1;
    o = '0;
    o.log_cleared_event = 1'b1; o.log_user = 8'h5a; o.log_port = 4'h3;
    o.loop_mode_event = 1'b1; o.holdover_state = 1'b1; o.loop_state = 2'h2;
    o.defaults_restored_event = 1'b1; o.def_user = 8'h21; o.def_set = 2'h3;
    o.user_set_saved_event = 1'b1; o.save_user = 8'h44;
    o.position_override = 1'b1; o.avg_count = 16'h1234;
    o.sync_change = 1'b1; o.sync_master = 1'b1;
    o.receiver_found_event = 1'b1; o.receiver_rev = 32'hc0de0102;
    op_i <= o;
    @(posedge clk_i);
    op_i <= '0;
    for (int t = 0; t < 200 && evq.size() < 7; t++) @(posedge clk_i);
    foreach (ep[k]) begin
      cmp(32'(evq[k].num), 32'(41 + k), "event number order");
      cmp(evq[k].p1, ep[k], "event parameter");
    end
    cmp(32'(evq[0].stamp != 32'h0), 32'h1, "time stamp");
    wb(1'b1, `AQE_PRES_OFS, 32'hffffffbf); cond_i[6] <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp(lv(6), 32'h0, "disabled source quiet");
    wb(1'b1, `AQE_PRES_OFS, 32'hffffffff);
    repeat (3) @(posedge clk_i);
    cmp(32'(critical_o), 32'h1, "critical summary");
    // mid-run reset must bring back the defaults
    wb(1'b1, `AQE_ELEV_OFS, 32'h5);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0; cond_i <= '0;
    @(posedge clk_i);
    cmp(32'({critical_o, evt_valid_o, ack_o}), 32'h0, "outputs after reset");
    cmp(32'(level_o == 48'h0), 32'h1, "levels after reset");
    wb(1'b0, `AQE_ELEV_OFS, 32'h0); cmp(q, 32'h14a78, "elevation after reset");
    wb(1'b0, `AQE_STAMP_OFS, 32'h0); cmp(q, 32'h0, "stamp after reset");
    print_verdict;
  end
endmodule
`default_nettype wire
